// [logic/dpc_ctrl.sv]
// dpc_ctrl: power-down, idle, slow idle, clock output and reset/boot control
// assumes MCLK is the core clock (twice the input clock) and an APB master
`timescale 1ns/1ps
module dpc_ctrl
   import dpc_pkg::*;
#(
   parameter int OSC_WAIT = OSC_CYC,
   parameter int RESUME_WAIT = RESUME_CYC
) (
   // clock and reset
   input wire logic MCLK,
   input wire logic ARST_N,
   // apb slave
   input wire logic PSEL,
   input wire logic PENABLE,
   input wire logic PWRITE,
   input wire logic [7:0] PADDR,
   input wire logic [31:0] PWDATA,
   output logic [31:0] PRDATA,
   output logic PREADY,
   output logic PSLVERR,
   // system pins
   input wire logic POWER_DOWN_REQUEST_N,
   output logic POWER_DOWN_ACK,
   input wire logic MEMORY_MAP_SELECT,
   input wire logic BUS_REQUEST,
   input wire logic IRQ_PENDING,
   // clocks and core control
   output logic PROCESSOR_CLOCK_OUTPUT,
   output logic CORE_TICK,
   output logic SERIAL_TICK,
   output logic TIMER_TICK,
   output logic CORE_RUN,
   output logic CONTEXT_CLEAR,
   output logic STACK_CLEAR,
   output logic PD_IRQ,
   output logic [15:0] FETCH_ADDR,
   output logic [15:0] MODE_STATUS_WORD,
   output logic [15:0] INTERRUPT_MASK_REGISTER
);
   import dpc_pkg::*;

   initial begin
      if (OSC_WAIT < 1 || RESUME_WAIT < 1 || OSC_WAIT > 65535 || RESUME_WAIT > 65535)
         $error("dpc_ctrl: wait counts out of range");
   end

   dpc_div_if dv();
   dpc_state_t st_r;
   logic [15:0] cnt_r;
   logic force_r, enter_r, ctx_clr_r, crystal_pin_off_r, clock_output_disable_r, pd_pend_r, wake_r;
   logic [2:0] div_r;
   logic pwd_q_r, processor_clock_output_r, first_r;
   logic wr, rd, pwd_fall, pd_req, enter_cmd, idle_cmd, ctx_r;

   // ****************************************
   // divider
   // ****************************************
   assign dv.sel = (st_r == ST_IDLE || st_r == ST_WAKE) ? div_r : IDLE_DIV_NONE;
   dpc_divider u_div (
      .MCLK(MCLK),
      .ARST_N(ARST_N),
      .dv(dv)
   );

   // ****************************************
   // apb decode
   // ****************************************
   assign wr = PSEL && PENABLE && PWRITE;
   assign rd = PSEL && !PWRITE;
   assign PREADY = 1'b1;
   assign PSLVERR = PSEL && PENABLE && !(PADDR == ADDR_CTRL || PADDR == ADDR_IDLE
      || PADDR == ADDR_STATUS || PADDR == ADDR_IRQ || PADDR == ADDR_ABUF);
   assign enter_cmd = wr && PADDR == ADDR_CTRL && PWDATA[CTRL_ENTER];
   assign idle_cmd = wr && PADDR == ADDR_CTRL && PWDATA[CTRL_IDLE_GO];
   assign pwd_fall = pwd_q_r && !POWER_DOWN_REQUEST_N;
   assign pd_req = pwd_fall || (wr && PADDR == ADDR_CTRL && PWDATA[CTRL_FORCE_PD]
      && !force_r);

   always_ff @(posedge MCLK or negedge ARST_N) begin
      if (!ARST_N) begin
         force_r <= 1'b0;
         ctx_clr_r <= 1'b0;
         crystal_pin_off_r <= 1'b0;
         div_r <= IDLE_DIV_NONE;
         clock_output_disable_r <= 1'b0;
      end else if (wr) begin
         case (PADDR)
            ADDR_CTRL: begin
               force_r <= PWDATA[CTRL_FORCE_PD];
               ctx_clr_r <= PWDATA[CTRL_CTX_CLEAR];
               crystal_pin_off_r <= PWDATA[CTRL_CRYSTAL_PIN_OFF];
            end
            ADDR_IDLE: div_r <= (PWDATA[2:0] > 3'h4) ? IDLE_DIV_NONE : PWDATA[2:0];
            ADDR_ABUF: clock_output_disable_r <= PWDATA[ABUF_CLOCK_OUTPUT_DISABLE];
            default: ;
         endcase
      end
   end

   // edge-sensitive, non-maskable pending flag; a new edge beats the clear
   always_ff @(posedge MCLK or negedge ARST_N) begin
      if (!ARST_N) begin
         pwd_q_r <= 1'b1;
         pd_pend_r <= 1'b0;
      end else begin
         pwd_q_r <= POWER_DOWN_REQUEST_N;
         if (pd_req) begin
            pd_pend_r <= 1'b1;
         end else if (wr && PADDR == ADDR_IRQ && PWDATA[IRQ_PD_PEND]) begin
            pd_pend_r <= 1'b0;
         end
      end
   end
   assign PD_IRQ = pd_pend_r;

   always_ff @(posedge MCLK or negedge ARST_N) begin
      if (!ARST_N) begin
         PRDATA <= 32'h0000_0000;
      end else if (rd && !PENABLE) begin
         case (PADDR)
            ADDR_CTRL: PRDATA <= {27'h0, 1'b0, crystal_pin_off_r, ctx_clr_r, 1'b0, force_r};
            ADDR_IDLE: PRDATA <= {29'h0, div_r};
            ADDR_STATUS: PRDATA <= {25'h0, POWER_DOWN_ACK, 3'h0, 3'(st_r)};
            ADDR_IRQ: PRDATA <= {30'h0, wake_r, pd_pend_r};
            ADDR_ABUF: PRDATA <= {31'h0, clock_output_disable_r};
            default: PRDATA <= 32'h0000_0000;
         endcase
      end
   end

   // ****************************************
   // main sequencer
   // ****************************************
   always_ff @(posedge MCLK or negedge ARST_N) begin
      if (!ARST_N) begin
         st_r <= ST_BOOT;
         cnt_r <= 16'h0000;
         ctx_r <= 1'b0;
         wake_r <= 1'b0;
      end else begin
         case (st_r)
            ST_BOOT: begin
               // boot loading runs only while MEMORY_MAP_SELECT is low and the bus is free
               if (BUS_REQUEST) begin
                  cnt_r <= 16'h0000;
               end else if (MEMORY_MAP_SELECT || cnt_r == 16'(BOOT_CYC - 1)) begin
                  st_r <= ST_RUN;
                  cnt_r <= 16'h0000;
               end else begin
                  cnt_r <= cnt_r + 16'h0001;
               end
            end
            ST_RUN: begin
               if (enter_cmd) begin
                  st_r <= ST_PD;
               end else if (idle_cmd) begin
                  st_r <= ST_IDLE;
               end
            end
            ST_IDLE: begin
               if (IRQ_PENDING || pd_req) begin
                  st_r <= ST_WAKE;
               end
            end
            ST_WAKE: begin
               // leave only on a divided tick: up to n cycles of latency
               if (dv.tick) begin
                  st_r <= ST_RUN;
                  wake_r <= 1'b1;
               end
            end
            ST_PD: begin
               if (pwd_fall || (!POWER_DOWN_REQUEST_N && !pwd_q_r && 1'b0)) begin
                  st_r <= ST_PD;
               end else if (POWER_DOWN_REQUEST_N && !pwd_q_r) begin
                  st_r <= ST_RESUME;
                  cnt_r <= 16'h0000;
                  ctx_r <= ctx_clr_r;
               end
            end
            ST_RESUME: begin
               if (cnt_r == 16'(crystal_pin_off_r ? OSC_WAIT - 1 : RESUME_WAIT - 1)) begin
                  st_r <= ST_RUN;
                  cnt_r <= 16'h0000;
               end else begin
                  cnt_r <= cnt_r + 16'h0001;
               end
            end
            default: st_r <= ST_BOOT;
         endcase
         if (wr && PADDR == ADDR_IRQ && PWDATA[IRQ_WAKE] && !(st_r == ST_WAKE && dv.tick)) begin
            wake_r <= 1'b0;
         end
      end
   end

   // ack follows the dormant state; reset drops it at once
   always_ff @(posedge MCLK or negedge ARST_N) begin
      if (!ARST_N) begin
         POWER_DOWN_ACK <= 1'b0;
      end else begin
         POWER_DOWN_ACK <= (st_r == ST_PD);
      end
   end

   // ****************************************
   // clocks: core cycle is twice the input clock, shown on the clock output
   // ****************************************
   always_ff @(posedge MCLK or negedge ARST_N) begin
      if (!ARST_N) begin
         processor_clock_output_r <= 1'b0;
         first_r <= 1'b1;
      end else begin
         processor_clock_output_r <= dv.tick && !clock_output_disable_r && st_r != ST_PD;
         first_r <= (st_r == ST_BOOT);
      end
   end
   assign PROCESSOR_CLOCK_OUTPUT = processor_clock_output_r;
   assign CORE_TICK = dv.tick && (st_r != ST_PD);
   assign SERIAL_TICK = dv.tick && (st_r != ST_PD);
   assign TIMER_TICK = dv.tick && (st_r != ST_PD);
   assign CORE_RUN = (st_r == ST_RUN || st_r == ST_IDLE || st_r == ST_WAKE);
   assign CONTEXT_CLEAR = ctx_r && st_r == ST_RESUME;
   assign STACK_CLEAR = first_r;
   assign FETCH_ADDR = (st_r == ST_BOOT) ? BOOT_PC : (pd_pend_r ? PD_VECTOR : BOOT_PC);
   assign MODE_STATUS_WORD = 16'h0000;
   assign INTERRUPT_MASK_REGISTER = 16'h0000;
   // the unused ctrl bit reads back as zero; is the outside party's
endmodule

// [logic/dpc_pkg.sv]
// dpc_pkg: constants and types shared by the power, clock and reset controller
// assumes a single 250 MHz clock domain and an APB register port
package dpc_pkg;

   // ****************************************
   // register map (byte addresses)
   // ****************************************
   localparam logic [7:0] ADDR_CTRL = 8'h00;
   localparam logic [7:0] ADDR_IDLE = 8'h04;
   localparam logic [7:0] ADDR_STATUS = 8'h08;
   localparam logic [7:0] ADDR_IRQ = 8'h0C;
   localparam logic [7:0] ADDR_ABUF = 8'h10;

   // ****************************************
   // field positions
   // ****************************************
   localparam int CTRL_FORCE_PD = 0;
   localparam int CTRL_ENTER = 1;
   localparam int CTRL_CTX_CLEAR = 2;
   localparam int CTRL_CRYSTAL_PIN_OFF = 3;
   localparam int CTRL_IDLE_GO = 4;
   localparam int ABUF_CLOCK_OUTPUT_DISABLE = 0;
   localparam int IRQ_PD_PEND = 0;
   localparam int IRQ_WAKE = 1;

   // ****************************************
   // reset values and encodings
   // ****************************************
   localparam logic [31:0] CTRL_RST = 32'h0000_0000;
   localparam logic [2:0] IDLE_DIV_NONE = 3'h0;
   localparam logic [15:0] PD_VECTOR = 16'h002C;
   localparam logic [15:0] BOOT_PC = 16'h0000;

   // ****************************************
   // timing, in input-clock cycles (core clock runs at twice that rate)
   // ****************************************
   localparam int RESUME_IN_CYC = 300;
   localparam int OSC_IN_CYC = 4096;
   localparam int CORE_PER_IN = 2;
   localparam int RESUME_CYC = RESUME_IN_CYC * CORE_PER_IN;
   localparam int OSC_CYC = OSC_IN_CYC * CORE_PER_IN;
   localparam int BOOT_CYC = 16;

   typedef enum {
      ST_BOOT,
      ST_RUN,
      ST_IDLE,
      ST_WAKE,
      ST_PD,
      ST_RESUME
   } dpc_state_t;

endpackage

// [logic/dpc_div_if.sv]
// dpc_div_if: carries the slow-idle divisor request and the divided tick
// assumes both ends sit on the same clock
`timescale 1ns/1ps
interface dpc_div_if;
   logic [2:0] sel;
   logic tick;
   modport ctl (output sel, input tick);
   modport div (input sel, output tick);
endinterface

// [logic/dpc_divider.sv]
// dpc_divider: produces a one-cycle tick every n cycles, n = 1/16/32/64/128
// assumes sel is held stable while divided operation lasts
`timescale 1ns/1ps
module dpc_divider
   import dpc_pkg::*;
(
   // clock and reset
   input wire logic MCLK,
   input wire logic ARST_N,
   // divisor link
   dpc_div_if.div dv
);
   logic [6:0] cnt_r;
   logic [6:0] lim;

   // ****************************************
   // divisor decode
   // ****************************************
   always_comb begin
      case (dv.sel)
         3'h1: lim = 7'h0F;
         3'h2: lim = 7'h1F;
         3'h3: lim = 7'h3F;
         3'h4: lim = 7'h7F;
         default: lim = 7'h00;
      endcase
   end

   always_ff @(posedge MCLK or negedge ARST_N) begin
      if (!ARST_N) begin
         cnt_r <= 7'h00;
      end else if (cnt_r >= lim) begin
         cnt_r <= 7'h00;
      end else begin
         cnt_r <= cnt_r + 7'h01;
      end
   end

   // divide by one when no divisor is given
   assign dv.tick = (cnt_r >= lim);
endmodule

// [testbench/dpc_ctrl_props.sv]
// dpc_ctrl_props: timing checks on the controller's pins
// assumes one clock, MCLK, and the bind below
`timescale 1ns/1ps
module dpc_ctrl_props (
   // clock and reset
   input wire logic MCLK,
   input wire logic ARST_N,
   // watched pins
   input wire logic POWER_DOWN_REQUEST_N,
   input wire logic POWER_DOWN_ACK,
   input wire logic PROCESSOR_CLOCK_OUTPUT,
   input wire logic CORE_TICK,
   input wire logic SERIAL_TICK,
   input wire logic TIMER_TICK,
   input wire logic CORE_RUN,
   input wire logic STACK_CLEAR,
   input wire logic PD_IRQ,
   input wire logic [15:0] FETCH_ADDR,
   input wire logic [15:0] MODE_STATUS_WORD,
   input wire logic [15:0] INTERRUPT_MASK_REGISTER
);
   // ****
   // checks
   // ****
   default clocking @(posedge MCLK); endclocking
   default disable iff (!ARST_N);
   sequence pd_exit_s;
      POWER_DOWN_ACK && $rose(POWER_DOWN_REQUEST_N);
   endsequence
   // both resume waits are longer than eight cycles
   sequence hold_s;
      !CORE_RUN [*8];
   endsequence
   AST_PD_IRQ: assert property ($fell(POWER_DOWN_REQUEST_N) |=> PD_IRQ)
      else $error("request not flagged");
   AST_VECTOR: assert property (PD_IRQ |-> FETCH_ADDR == 16'h002C)
      else $error("wrong vector");
   AST_ACK_DROP: assert property (pd_exit_s |-> ##[1:2] !POWER_DOWN_ACK)
      else $error("ack stuck");
   AST_RESUME: assert property ($fell(POWER_DOWN_ACK) |-> hold_s)
      else $error("resumed early");
   AST_PD_HALT: assert property (POWER_DOWN_ACK |-> !CORE_RUN)
      else $error("running in power-down");
   AST_TICKS: assert property (SERIAL_TICK == CORE_TICK && TIMER_TICK == CORE_TICK)
      else $error("ticks differ");
   AST_PROCESSOR_CLOCK_OUTPUT: assert property (PROCESSOR_CLOCK_OUTPUT |-> $past(CORE_TICK))
      else $error("clock out without tick");
   AST_RST_CLR: assert property ($rose(ARST_N) |-> STACK_CLEAR && MODE_STATUS_WORD == 16'h0000
      && INTERRUPT_MASK_REGISTER == 16'h0000)
      else $error("reset state wrong");
   AST_BOOT: assert property ($fell(STACK_CLEAR) |-> FETCH_ADDR == 16'h0000)
      else $error("boot fetch wrong");
endmodule
bind dpc_ctrl dpc_ctrl_props i_dpc_ctrl_props (.*);

// [testbench/dpc_sys_model.sv]
// dpc_sys_model: outside system logic on the request, map and irq pins
// assumes the bench calls its tasks; pins move just after MCLK rises
`timescale 1ns/1ps
module dpc_sys_model (
   // clock
   input wire logic MCLK,
   // system pins
   output logic pd_req_n,
   output logic map_sel,
   output logic bus_req,
   output logic irq
);
   initial begin
      pd_req_n = 1'b1;
      map_sel = 1'b0;
      bus_req = 1'b0;
      irq = 1'b0;
   end
   task automatic pin(input logic v);
      @(posedge MCLK);
      pd_req_n <= v;
   endtask
   // boot straps; set while reset is low so that the release sees them
   task automatic boot_cfg(input logic m, input logic b);
      @(posedge MCLK);
      map_sel <= m;
      bus_req <= b;
   endtask
   // one interrupt at a time, held until the bench lowers it
   task automatic req(input logic v);
      @(posedge MCLK);
      irq <= v;
   endtask
endmodule

// [testbench/tb_dsp_power_clock_reset_control.sv]
// tb: APB-driven checks of power-down, idle and reset behaviour
// assumes dpc_ctrl with short waits and the system model on its pins
`timescale 1ns/1ps
`define CHK(nm, e, v) begin n_compared++; if ((v) !== (e)) begin n_errors++; \
   $display("mismatch %s expected %0h seen %0h", nm, e, v); end end
module tb_dsp_power_clock_reset_control;
   import dpc_pkg::*;
   logic MCLK, ARST_N, PSEL, PENABLE, PWRITE, PREADY, PSLVERR, POWER_DOWN_REQUEST_N;
   logic POWER_DOWN_ACK, MEMORY_MAP_SELECT, BUS_REQUEST, IRQ_PENDING, PROCESSOR_CLOCK_OUTPUT;
   logic CORE_TICK, SERIAL_TICK, TIMER_TICK, CORE_RUN, CONTEXT_CLEAR, STACK_CLEAR, PD_IRQ;
   logic serr, s;
   logic [7:0] PADDR;
   logic [31:0] PWDATA, PRDATA, rd;
   logic [15:0] FETCH_ADDR, MODE_STATUS_WORD, INTERRUPT_MASK_REGISTER;
   int n_errors = 0, n_compared = 0, cyc = 0, k, n;
   // ****
   // harness
   // ****
   dpc_ctrl #(.OSC_WAIT(20), .RESUME_WAIT(10)) i_dpc_ctrl (.*);
   dpc_sys_model i_dpc_sys_model (.MCLK(MCLK), .pd_req_n(POWER_DOWN_REQUEST_N),
      .map_sel(MEMORY_MAP_SELECT), .bus_req(BUS_REQUEST), .irq(IRQ_PENDING));
   initial begin
      MCLK = 1'b0;
      forever #2 MCLK = ~MCLK;
   end
   always @(posedge MCLK) begin
      cyc++;
      if (cyc == 5000) begin
         n_errors++;
         summarize();
      end
   end
   task automatic summarize;
      $display("errors %0d compared %0d", n_errors, n_compared);
      if (n_errors == 0 && n_compared > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge MCLK);
      PSEL <= 1'b1;
      PWRITE <= w;
      PADDR <= a;
      PWDATA <= d;
      @(posedge MCLK);
      PENABLE <= 1'b1;
      @(posedge MCLK);
      while (PREADY !== 1'b1) @(posedge MCLK);
      rd = PRDATA;
      serr = PSLVERR;
      PSEL <= 1'b0;
      PENABLE <= 1'b0;
   endtask
   // counts edges until the core runs; also notes any context clear seen
   task automatic wait_run(output int c, output logic f);
      c = 0;
      f = 1'b0;
      while (CORE_RUN !== 1'b1 && c < 1000) begin
         @(posedge MCLK);
         c++;
         f = f | CONTEXT_CLEAR;
      end
   endtask
   // ****
   // tests
   // ****
   initial begin
      ARST_N = 1'b0;
      {PSEL, PENABLE, PWRITE, PADDR, PWDATA} = '0;
      repeat (3) @(posedge MCLK);
      `CHK("stack clear", 1'b1, STACK_CLEAR)
      ARST_N <= 1'b1;
      wait_run(n, s);
      `CHK("boot length", 1'b1, n >= BOOT_CYC - 1 && n <= BOOT_CYC + 2)
      `CHK("fetch", BOOT_PC, FETCH_ADDR)
      `CHK("mode word", 16'h0000, MODE_STATUS_WORD)
      `CHK("mask", 16'h0000, INTERRUPT_MASK_REGISTER)
      apb(1'b0, 8'h14, 32'h0);
      `CHK("unmapped err", 1'b1, serr)
      i_dpc_sys_model.pin(1'b0);
      apb(1'b0, ADDR_IRQ, 32'h0);
      `CHK("pd pending", 1'b1, rd[IRQ_PD_PEND])
      `CHK("vector", PD_VECTOR, FETCH_ADDR)
      apb(1'b1, ADDR_CTRL, 32'h2);
      apb(1'b0, ADDR_STATUS, 32'h0);
      `CHK("status", 7'h44, rd[6:0])
      i_dpc_sys_model.pin(1'b1);
      wait_run(n, s);
      `CHK("resume", 1'b1, n >= 10 && n <= 14)
      apb(1'b1, ADDR_IRQ, 32'h3);
      apb(1'b1, ADDR_CTRL, 32'hD);
      // the flag is loaded at the access edge; look once it has settled
      @(negedge MCLK);
      `CHK("force flag", 1'b1, PD_IRQ)
      apb(1'b1, ADDR_CTRL, 32'hF);
      i_dpc_sys_model.pin(1'b0);
      i_dpc_sys_model.pin(1'b1);
      wait_run(n, s);
      `CHK("osc wait", 1'b1, n >= 20 && n <= 24)
      `CHK("ctx clear", 1'b1, s)
      apb(1'b1, ADDR_CTRL, 32'h0);
      apb(1'b1, ADDR_IRQ, 32'h3);
      i_dpc_sys_model.pin(1'b0);
      apb(1'b1, ADDR_CTRL, 32'h2);
      // ack lags the dormant state by one edge
      repeat (2) @(negedge MCLK);
      `CHK("ack", 1'b1, POWER_DOWN_ACK)
      ARST_N <= 1'b0;
      i_dpc_sys_model.pin(1'b1);
      i_dpc_sys_model.boot_cfg(1'b1, 1'b0);
      `CHK("ack on reset", 1'b0, POWER_DOWN_ACK)
      ARST_N <= 1'b1;
      wait_run(n, s);
      `CHK("no boot", 1'b1, n <= 2)
      apb(1'b1, ADDR_ABUF, 32'h1);
      // the pulse launched at the write edge still uses the old disable bit
      @(posedge MCLK);
      s = 1'b0;
      repeat (40) @(posedge MCLK) s = s | PROCESSOR_CLOCK_OUTPUT;
      `CHK("processor_clock_output off", 1'b0, s)
      apb(1'b1, ADDR_ABUF, 32'h0);
      repeat (4) @(posedge MCLK) s = s | PROCESSOR_CLOCK_OUTPUT;
      `CHK("processor_clock_output on", 1'b1, s)
      ARST_N <= 1'b0;
      i_dpc_sys_model.boot_cfg(1'b0, 1'b1);
      ARST_N <= 1'b1;
      repeat (30) @(posedge MCLK);
      `CHK("boot held", 1'b0, CORE_RUN)
      i_dpc_sys_model.boot_cfg(1'b0, 1'b0);
      wait_run(n, s);
      `CHK("boot after bus", 1'b1, n >= BOOT_CYC - 1 && n <= BOOT_CYC + 2)
      for (k = 0; k <= 4; k++) begin
         apb(1'b1, ADDR_IDLE, 32'(k));
         apb(1'b1, ADDR_CTRL, 32'h10);
         if (k > 0) begin
            n = 0;
            while (CORE_TICK !== 1'b1 && n < 300) begin @(posedge MCLK); n++; end
            @(posedge MCLK);
            n = 1;
            while (CORE_TICK !== 1'b1 && n < 300) begin @(posedge MCLK); n++; end
            `CHK("divisor", 8 << k, n)
         end
         i_dpc_sys_model.req(1'b1);
         // run level holds in idle too, so back in run means ticks on two edges in a row
         n = 0;
         s = 1'b0;
         while (!(s && CORE_TICK === 1'b1) && n < 300) begin
            s = CORE_TICK;
            @(posedge MCLK);
            n++;
         end
         `CHK("wake", 1'b1, n <= (k ? 8 << k : 1) + 4)
         i_dpc_sys_model.req(1'b0);
      end
      summarize();
   end
endmodule
